// file: lpm_pkg.sv
// Package of constants and types for the low-power mode controller
package lpm_pkg;
   // Oscillator start-up delay after STOP, in internal clock cycles
   localparam int unsigned STARTUP_CYCLES = 2048;
   localparam int          STARTUP_W      = 12;
   localparam logic [STARTUP_W-1:0] STARTUP_LAST = STARTUP_W'(STARTUP_CYCLES - 1);
   localparam logic [STARTUP_W-1:0] STARTUP_ZERO = 12'h000;

   // APB register byte offsets
   localparam logic [7:0] OFS_IOPT   = 8'h00;  // Interrupt option register, write only
   localparam logic [7:0] OFS_CMD    = 8'h04;  // Low-power instruction command
   localparam logic [7:0] OFS_STATUS = 8'h08;  // Mode and context status
   localparam logic [7:0] OFS_OPTION = 8'h0c;  // Option byte image

   // Field positions
   localparam int GIE_BIT     = 4;  // Global interrupt enable in the option register
   localparam int CMD_WAIT    = 0;  // Command: execute wait instruction
   localparam int CMD_STOP    = 1;  // Command: execute halt instruction
   localparam int OPT_EXTSTOP = 0;  // External stop control option bit

   // Reset values
   localparam logic [7:0] IOPT_RESET = 8'h00;
   localparam logic       OPT_RESET  = 1'b0;

   // Vector addresses of the restart routines
   localparam logic [11:0] VEC_RESET = 12'hffe;
   localparam logic [11:0] VEC_NMI   = 12'hffc;
   localparam logic [11:0] VEC_PORTA = 12'hff6;
   localparam logic [11:0] VEC_PORTB = 12'hff4;
   localparam logic [11:0] VEC_TIMER = 12'hff2;
   localparam logic [11:0] VEC_ADC   = 12'hff0;

   // Controller states
   typedef enum logic [1:0] {
      LPM_RUN,
      LPM_WAIT,
      LPM_STOP,
      LPM_STARTUP
   } lpm_state_t;

   // Core context at the moment of the low-power instruction
   typedef enum logic [1:0] {
      CTX_MAIN,
      CTX_INT,
      CTX_NMI
   } lpm_ctx_t;

   // Restart action handed to the core
   typedef enum logic [1:0] {
      RST_NEXT,    // Continue after the instruction
      RST_VECTOR,  // Jump to service routine, then return after instruction
      RST_NMI_FIRST // Run NMI routine, then continue in interrupt context
   } lpm_restart_t;
endpackage

// file: lpm_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of asynchronous inputs
module lpm_sync
   import lpm_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

   // Each bit passes two flops before any logic sees it
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               meta_q[g]   <= 1'b0;
               sync_out[g] <= 1'b0;
            end else begin
               meta_q[g]   <= async_in[g];
               sync_out[g] <= meta_q[g];
            end
         end
      end
   endgenerate
endmodule

// file: lpm_ctrl.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
// Low-power mode controller: WAIT/STOP sequencing, wake-up, start-up delay and restart context
// How it works
// - Wait instruction freezes CPU, peripherals run
// - RAM and registers kept while asleep
// - Selected oscillator keeps peripheral clock in WAIT
// - WAIT exits on reset or interrupt
// - Restart loads service or reset vector
// - Halt instruction stops CPU and oscillator
// - STOP exits on reset, external interrupts
// - 2048 cycle oscillator start-up after STOP
// - Watchdog turns halt into wait, with exception
// - Watchdog frozen during permitted STOP
// - NMI cannot wake with interrupts disabled
// - Main context: service, then next instruction
// - NMI context: resume, stay in NMI
// - Interrupt context, maskable wake: resume routine
// - Interrupt context, NMI wake: NMI first
// - Instruction ignored when enabled interrupt pending
// - Global enable is option register bit 4
// - Reset starts in RUN on main oscillator
module lpm_ctrl
   import lpm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Core status, same clock domain
   input  wire logic        core_in_int_in,   // Core runs a maskable service routine
   input  wire logic        core_in_nmi_in,   // Core runs the NMI routine
   input  wire logic        wdg_active_in,    // Watchdog enabled
   input  wire logic        bko_sel_in,       // Backup oscillator selected
   // Wake sources, asynchronous
   input  wire logic        nmi_pin_in,       // NMI pin level
   input  wire logic        nmi_req_in,       // NMI request latched
   input  wire logic        porta_irq_in,
   input  wire logic        portb_irq_in,
   input  wire logic        timer_irq_in,
   input  wire logic        timer_ext_clk_in, // Timer runs on an external clock
   input  wire logic        adc_irq_in,
   input  wire logic        wake_reset_in,    // Watchdog, detector or pin reset request
   // Clock and restart controls
   output logic             cpu_clk_en_out,
   output logic             periph_clk_en_out,
   output logic             main_osc_en_out,
   output logic             bko_en_out,
   output logic             wdg_freeze_out,
   output logic             retain_out,
   output logic             pc_load_out,
   output logic      [11:0] pc_vector_out,
   output logic      [1:0]  restart_out,
   output logic             keep_ctx_out,
   output logic      [1:0]  mode_out
);
   // Synchronised wake inputs
   logic [6:0] raw_w;
   logic [6:0] syn_w;
   logic       s_nmi_pin, s_nmi, s_pa, s_pb, s_tim, s_adc, s_rst;

   // Registers
   lpm_state_t state_q, state_d;        // Controller state
   lpm_ctx_t   ctx_q;                   // Context at entry
   logic [7:0] iopt_q;                  // Interrupt option register
   logic       opt_extstop_q;           // External stop control option
   logic [STARTUP_W-1:0] cnt_q;         // Start-up counter
   logic [11:0] vec_q;                  // Vector for restart
   logic       wake_nmi_q;              // Wake came from NMI
   logic       wake_rst_q;              // Wake came from a reset

   // Bus decode
   logic wr_acc, rd_acc;
   logic gie;
   logic req_wait, req_stop;
   logic pend_any;
   logic wake_any;
   logic enter_wait, enter_stop;

   assign raw_w = {wake_reset_in, adc_irq_in, timer_irq_in, portb_irq_in, porta_irq_in, nmi_req_in, nmi_pin_in};

   // Pin inputs come from other domains; synchronise them first
   lpm_sync #(
      .WIDTH (7)
   ) u_sync (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in (raw_w),
      .sync_out (syn_w)
   );

   assign s_nmi_pin = syn_w[0];
   assign s_nmi     = syn_w[1];
   assign s_pa      = syn_w[2];
   assign s_pb      = syn_w[3];
   assign s_tim     = syn_w[4];
   assign s_adc     = syn_w[5];
   assign s_rst     = syn_w[6];

   // Vector of highest-priority maskable source
   function automatic logic [11:0] mask_vec(input logic pa, input logic pb, input logic tim, input logic adc);
      if (pa) begin
         mask_vec = VEC_PORTA;
      end else if (pb) begin
         mask_vec = VEC_PORTB;
      end else if (tim) begin
         mask_vec = VEC_TIMER;
      end else if (adc) begin
         mask_vec = VEC_ADC;
      end else begin
         mask_vec = VEC_RESET;
      end
   endfunction

   // Writes land only at the edge where the master samples pready high
   assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;
   assign rd_acc = psel_in && penable_in && !pwrite_in;

   assign gie = iopt_q[GIE_BIT];

   assign req_wait = wr_acc && (paddr_in == OFS_CMD) && pwdata_in[CMD_WAIT];
   assign req_stop = wr_acc && (paddr_in == OFS_CMD) && pwdata_in[CMD_STOP] && !pwdata_in[CMD_WAIT];

   assign pend_any = s_nmi || (gie && (s_pa || s_pb || s_tim || s_adc));

   // halt becomes wait under watchdog unless option and NMI high
   assign enter_stop = req_stop && !pend_any && (!wdg_active_in || (opt_extstop_q && s_nmi_pin));
   assign enter_wait = !pend_any && (req_wait || (req_stop && !enter_stop));

   // Wake condition per state
   always_comb begin
      wake_any = s_rst;
      case (state_q)
         // any enabled interrupt or reset ends WAIT; NMI needs enable too
         LPM_WAIT: wake_any = s_rst || (gie && (s_nmi || s_pa || s_pb || s_tim || s_adc));
         // only sources alive without the oscillator end STOP
         LPM_STOP: wake_any = s_rst || (gie && (s_nmi || s_pa || s_pb || (s_tim && timer_ext_clk_in)));
         default:  wake_any = s_rst;
      endcase
   end

   // Next-state logic
   always_comb begin
      state_d = state_q;
      case (state_q)
         LPM_RUN: begin
            if (enter_wait) begin
               state_d = LPM_WAIT;
            end else if (enter_stop) begin
               state_d = LPM_STOP;
            end
         end
         LPM_WAIT: begin
            if (wake_any) begin
               state_d = LPM_RUN;
            end
         end
         LPM_STOP: begin
            if (wake_any) begin
               state_d = LPM_STARTUP;
            end
         end
         LPM_STARTUP: begin
            if (cnt_q == STARTUP_ZERO) begin
               state_d = LPM_RUN;
            end
         end
         default: state_d = LPM_RUN;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= LPM_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // start-up counter, loaded on STOP wake
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= STARTUP_ZERO;
      end else if (state_q == LPM_STOP && wake_any) begin
         cnt_q <= STARTUP_LAST;
      end else if (state_q == LPM_STARTUP && cnt_q != STARTUP_ZERO) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Context captured when a low-power state is entered
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctx_q <= CTX_MAIN;
      end else if (state_q == LPM_RUN && (enter_wait || enter_stop)) begin
         if (core_in_nmi_in) begin
            ctx_q <= CTX_NMI;
         end else if (core_in_int_in) begin
            ctx_q <= CTX_INT;
         end else begin
            ctx_q <= CTX_MAIN;
         end
      end
   end

   // Wake source captured; reset outranks NMI outranks maskable
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vec_q      <= VEC_RESET;
         wake_nmi_q <= 1'b0;
         wake_rst_q <= 1'b0;
      end else if ((state_q == LPM_WAIT || state_q == LPM_STOP) && wake_any) begin
         wake_rst_q <= s_rst;
         wake_nmi_q <= !s_rst && s_nmi;
         // vector of waking routine or reset
         if (s_rst) begin
            vec_q <= VEC_RESET;
         end else if (s_nmi) begin
            vec_q <= VEC_NMI;
         end else begin
            vec_q <= mask_vec(s_pa, s_pb, s_tim && (state_q == LPM_WAIT || timer_ext_clk_in), s_adc);
         end
      end
   end

   // Restart directive, one pulse when the CPU resumes
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pc_load_out   <= 1'b0;
         pc_vector_out <= VEC_RESET;
         restart_out   <= RST_NEXT;
         keep_ctx_out  <= 1'b0;
      end else if ((state_q == LPM_WAIT && state_d == LPM_RUN) ||
                   (state_q == LPM_STARTUP && state_d == LPM_RUN)) begin
         pc_vector_out <= vec_q;
         keep_ctx_out  <= 1'b0;
         pc_load_out   <= 1'b1;
         restart_out   <= RST_VECTOR;
         if (state_q == LPM_WAIT) begin
            // WAIT wake data is fresh this cycle
            pc_vector_out <= s_rst ? VEC_RESET : (s_nmi ? VEC_NMI : mask_vec(s_pa, s_pb, s_tim, s_adc));
         end
         if (!(state_q == LPM_WAIT ? s_rst : wake_rst_q)) begin
            case (ctx_q)
               CTX_MAIN: restart_out <= RST_VECTOR;
               // resume next instruction, stay in NMI
               CTX_NMI: begin
                  restart_out  <= RST_NEXT;
                  pc_load_out  <= 1'b0;
                  keep_ctx_out <= 1'b1;
               end
               CTX_INT: begin
                  keep_ctx_out <= 1'b1;
                  if (state_q == LPM_WAIT ? s_nmi : wake_nmi_q) begin
                     restart_out <= RST_NMI_FIRST;
                  end else begin
                     restart_out <= RST_NEXT;
                     pc_load_out <= 1'b0;
                  end
               end
               default: restart_out <= RST_VECTOR;
            endcase
         end
      end else begin
         pc_load_out <= 1'b0;
      end
   end

   // Clock gating and retention outputs
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cpu_clk_en_out    <= 1'b1;
         periph_clk_en_out <= 1'b1;
         main_osc_en_out   <= 1'b1;
         bko_en_out        <= 1'b0;
         wdg_freeze_out    <= 1'b0;
         retain_out        <= 1'b0;
      end else begin
         // CPU clock only in RUN; gated through start-up
         cpu_clk_en_out    <= (state_d == LPM_RUN);
         // selected oscillator keeps peripherals in WAIT
         periph_clk_en_out <= (state_d != LPM_STOP);
         main_osc_en_out   <= (state_d != LPM_STOP) && !bko_sel_in;
         bko_en_out        <= (state_d != LPM_STOP) && bko_sel_in;
         wdg_freeze_out    <= (state_d == LPM_STOP);
         // hold RAM and registers while asleep
         retain_out        <= (state_d != LPM_RUN);
      end
   end

   // Software-written registers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         iopt_q        <= IOPT_RESET;
         opt_extstop_q <= OPT_RESET;
      end else if (wr_acc) begin
         if (paddr_in == OFS_IOPT) begin
            iopt_q <= pwdata_in[7:0];
         end
         if (paddr_in == OFS_OPTION) begin
            opt_extstop_q <= pwdata_in[OPT_EXTSTOP];
         end
      end
   end

   // APB read data and response; interrupt option register reads as zero
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         mode_out    <= 2'h0;
      end else begin
         mode_out    <= state_d;
         // Ready for one cycle: two-cycle access phase
         pready_out  <= psel_in && penable_in && !pready_out;
         pslverr_out <= psel_in && penable_in && !pready_out &&
                        !(paddr_in == OFS_IOPT || paddr_in == OFS_CMD ||
                          paddr_in == OFS_STATUS || paddr_in == OFS_OPTION);
         prdata_out  <= 32'h0000_0000;
         if (rd_acc && !pready_out) begin
            case (paddr_in)
               OFS_STATUS: prdata_out <= {26'h0, ctx_q, state_q, wdg_active_in, s_nmi_pin};
               OFS_OPTION: prdata_out <= {31'h0, opt_extstop_q};
               default:    prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// file: lpm_ctrl_asserts.sv
// Concurrent checks on the low-power controller ports
`timescale 1ns/1ps
module lpm_ctrl_asserts
   import lpm_pkg::*;
(
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       rstn_in,
   // Bus handshake
   input wire logic       psel_in,
   input wire logic       penable_in,
   input wire logic       pready_out,
   input wire logic       pslverr_out,
   // Mode and clock controls
   input wire logic [1:0] mode_out,
   input wire logic       cpu_clk_en_out,
   input wire logic       periph_clk_en_out,
   input wire logic       main_osc_en_out,
   input wire logic       bko_en_out,
   input wire logic       wdg_freeze_out,
   input wire logic       retain_out,
   input wire logic       pc_load_out
);
   localparam int SU_MIN = 2048;  // Shortest legal start-up stay
   localparam int SU_MAX = 2049;  // Allows the one exit edge
   logic [12:0] su_cnt_q;         // Cycles spent in start-up
   // Counter, since a repetition of 2048 would crush the tools
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         su_cnt_q <= 13'h0000;
      end else if (mode_out == 2'h3) begin
         su_cnt_q <= su_cnt_q + 13'h0001;
      end else begin
         su_cnt_q <= 13'h0000;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_wait_cpu_frozen: assert property (mode_out == 2'h1 |-> !cpu_clk_en_out && periph_clk_en_out)
      else $error("cpu clock runs or peripherals stopped in wait");
   a_wait_osc_runs: assert property (mode_out == 2'h1 |-> main_osc_en_out || bko_en_out)
      else $error("no oscillator running in wait");
   a_stop_osc_off: assert property (mode_out == 2'h2 |-> !(periph_clk_en_out || main_osc_en_out || bko_en_out))
      else $error("clock still running in stop");
   a_sleep_retains: assert property (mode_out != 2'h0 |-> retain_out)
      else $error("retention dropped while asleep");
   a_startup_length: assert property (mode_out == 2'h3 ##1 mode_out != 2'h3 |-> su_cnt_q >= SU_MIN && su_cnt_q <= SU_MAX)
      else $error("start-up delay has the wrong length");
   a_stop_to_startup: assert property (mode_out == 2'h2 ##1 mode_out != 2'h2 |-> mode_out == 2'h3)
      else $error("stop left without start-up delay");
   a_startup_gated: assert property (mode_out == 2'h3 |-> !cpu_clk_en_out)
      else $error("cpu clock on during start-up");
   a_run_clocked: assert property (mode_out == 2'h0 |-> cpu_clk_en_out && periph_clk_en_out)
      else $error("run mode without clocks");
   a_freeze_in_stop: assert property (wdg_freeze_out |-> mode_out == 2'h2)
      else $error("watchdog frozen outside stop");
   a_load_single: assert property (pc_load_out |=> !pc_load_out)
      else $error("program counter load longer than one cycle");
   a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("bus answer not one cycle after access");
   a_err_with_ready: assert property (pslverr_out |-> pready_out && $past(penable_in))
      else $error("bus error outside an answer");
endmodule
bind lpm_ctrl lpm_ctrl_asserts i_chk (
   .clk_in, .rstn_in, .psel_in, .penable_in, .pready_out, .pslverr_out, .mode_out, .cpu_clk_en_out,
   .periph_clk_en_out, .main_osc_en_out, .bko_en_out, .wdg_freeze_out, .retain_out, .pc_load_out);

// file: lpm_core_model.sv
// Behavioural model of the CPU core context seen by the controller
`timescale 1ns/1ps
module lpm_core_model
   import lpm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // Context asked by the bench, restart from the controller
   input  wire logic [1:0]  ctx_req_in,
   input  wire logic        pc_load_in,
   input  wire logic [11:0] pc_vector_in,
   // Context reported to the controller
   output logic             core_in_int_out,
   output logic             core_in_nmi_out
);
   lpm_ctx_t ctx_q;  // Current core context
   // context tracking; service routines return at once, a reset load drops to main
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctx_q <= CTX_MAIN;
      end else if (pc_load_in && pc_vector_in == VEC_RESET) begin
         ctx_q <= CTX_MAIN;
      end else begin
         ctx_q <= lpm_ctx_t'(ctx_req_in);
      end
   end
   assign core_in_int_out = (ctx_q == CTX_INT);
   assign core_in_nmi_out = (ctx_q == CTX_NMI);
endmodule

// file: low_power_mode_controller_bench.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module low_power_mode_controller_bench
   import lpm_pkg::*;
;
   typedef struct packed {logic [31:0] v; logic [31:0] m;} lpm_note_t;
   logic        clk_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [7:0]  paddr_in;
   logic [31:0] pwdata_in, prdata_out;
   logic        core_in_int_in, core_in_nmi_in, wdg_active_in, bko_sel_in, nmi_pin_in, timer_ext_clk_in;
   logic [5:0]  src;  // porta, portb, timer, adc, nmi request, reset request
   logic        cpu_clk_en_out, periph_clk_en_out, main_osc_en_out, bko_en_out, wdg_freeze_out;
   logic        retain_out, pc_load_out, keep_ctx_out;
   logic [11:0] pc_vector_out;
   logic [1:0]  restart_out, mode_out, ctx_req, mode_prev;
   int          mismatches, cmp_count, seed;
   lpm_note_t   apb_q[$], load_q[$];  // Expected read data and restarts
   localparam logic [11:0] MVEC[4] = '{VEC_PORTA, VEC_PORTB, VEC_TIMER, VEC_ADC};
   lpm_ctrl i_dut (
      .clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .core_in_int_in, .core_in_nmi_in, .wdg_active_in, .bko_sel_in, .nmi_pin_in,
      .nmi_req_in(src[4]), .porta_irq_in(src[0]), .portb_irq_in(src[1]), .timer_irq_in(src[2]), .timer_ext_clk_in,
      .adc_irq_in(src[3]), .wake_reset_in(src[5]), .cpu_clk_en_out, .periph_clk_en_out, .main_osc_en_out,
      .bko_en_out, .wdg_freeze_out, .retain_out, .pc_load_out, .pc_vector_out, .restart_out, .keep_ctx_out, .mode_out);
   lpm_core_model i_core (.clk_in, .rstn_in, .ctx_req_in(ctx_req), .pc_load_in(pc_load_out),
      .pc_vector_in(pc_vector_out), .core_in_int_out(core_in_int_in), .core_in_nmi_out(core_in_nmi_in));
   // 100 MHz clock
   always #5 clk_in = ~clk_in;
   // Restart note: keep flag, restart code, vector
   function automatic logic [31:0] note(input logic k, input logic [1:0] r, input logic [11:0] vec);
      return {16'h0000, r != RST_NEXT, k, r, vec};
   endfunction
   // Option word with random edge selections and a chosen global enable
   function automatic logic [31:0] iopt_word(input logic g);
      return (32'($random(seed)) & 32'h00000060) | {27'h0000000, g, 4'h0};
   endfunction
   // One APB transfer; request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
      int n;
      if (!w) apb_q.push_back('{v: d, m: m});
      psel_in   <= 1'h1;
      pwrite_in <= w;
      paddr_in  <= a;
      pwdata_in <= w ? d : 32'h00000000;
      @(posedge clk_in);
      penable_in <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (!pready_out && n < 20);
      `CHK(pslverr_out, e)
      psel_in    <= 1'h0;
      penable_in <= 1'h0;
      @(posedge clk_in);
   endtask
   // Bounded wait for a mode
   task automatic wait_mode(input logic [1:0] md);
      int n;
      n = 0;
      while (mode_out !== md && n < 40) begin
         @(posedge clk_in);
         n++;
      end
      `CHK(mode_out, md)
   endtask
   // Raise a wake source until the core is restarted; long enough for start-up
   task automatic wake(input int i, input logic [31:0] v, input logic [31:0] m);
      int n;
      load_q.push_back('{v: v, m: m | 32'h00008000});
      src[i] <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (mode_out != 2'h0 && n < 3000);
      src[i] <= 1'h0;
      repeat (4) @(posedge clk_in);
   endtask
   // Monitor: oldest note against each answer that appears
   always @(posedge clk_in) begin
      lpm_note_t nt;
      if (pready_out && !pwrite_in) begin
         nt = apb_q.pop_front();
         `CHK(prdata_out & nt.m, nt.v & nt.m)
      end
      if (mode_out < mode_prev && load_q.size() == 0) begin
         mismatches++;
      end else if (mode_out < mode_prev) begin
         nt = load_q.pop_front();
         `CHK({16'h0000, pc_load_out, keep_ctx_out, restart_out, pc_vector_out} & nt.m, nt.v & nt.m)
      end
      mode_prev <= mode_out;
   end
   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the three start-up delays
   initial begin
      #600000;
      mismatches++;
      summarize();
   end
   // Main sequence
   initial begin
      {clk_in, rstn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {wdg_active_in, bko_sel_in, nmi_pin_in, timer_ext_clk_in, src, ctx_req} = '0;
      {mismatches, cmp_count} = '0;
      seed = 45;
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'h1;
      @(posedge clk_in);
      `CHK(main_osc_en_out, 1'h1)
      apb(1'h0, OFS_STATUS, 32'h00000000, 32'h0000003f, 1'h0);
      apb(1'h1, OFS_IOPT, iopt_word(1'h1), 32'h0, 1'h0);
      apb(1'h0, OFS_IOPT, 32'h00000000, 32'hffffffff, 1'h0);
      apb(1'h1, OFS_OPTION, 32'h00000001, 32'h0, 1'h0);
      apb(1'h0, OFS_OPTION, 32'h00000001, 32'h00000001, 1'h0);
      apb(1'h0, 8'h10, 32'h00000000, 32'h0, 1'h1);
      apb(1'h1, OFS_OPTION, 32'h00000000, 32'h0, 1'h0);
      $display("test registers done");
      // Wait from main, each maskable source; backup oscillator chosen first
      bko_sel_in <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, OFS_CMD, (i == 3) ? 32'h00000003 : 32'h00000001, 32'h0, 1'h0);
         wait_mode(2'h1);
         `CHK(bko_en_out, 1'h1)
         wake(i, note(1'h0, RST_VECTOR, MVEC[i]), 32'h00003fff);
      end
      $display("test wait done");
      // Stop: converter must not wake, timer on external clock and NMI must
      timer_ext_clk_in <= 1'h1;
      apb(1'h1, OFS_CMD, 32'h00000002, 32'h0, 1'h0);
      wait_mode(2'h2);
      src[3] <= 1'h1;
      repeat (20) @(posedge clk_in);
      `CHK(mode_out, 2'h2)
      src[3] <= 1'h0;
      wake(2, note(1'h0, RST_VECTOR, VEC_TIMER), 32'h00003fff);
      apb(1'h1, OFS_CMD, 32'h00000002, 32'h0, 1'h0);
      wait_mode(2'h2);
      wake(4, note(1'h0, RST_VECTOR, VEC_NMI), 32'h00003fff);
      $display("test stop done");
      // Watchdog running: halt becomes wait unless option set and NMI pin high
      wdg_active_in <= 1'h1;
      apb(1'h1, OFS_OPTION, 32'h00000001, 32'h0, 1'h0);
      apb(1'h1, OFS_CMD, 32'h00000002, 32'h0, 1'h0);
      wait_mode(2'h1);
      `CHK(wdg_freeze_out, 1'h0)
      wake(0, note(1'h0, RST_VECTOR, VEC_PORTA), 32'h00003fff);
      nmi_pin_in <= 1'h1;
      apb(1'h1, OFS_CMD, 32'h00000002, 32'h0, 1'h0);
      wait_mode(2'h2);
      `CHK(wdg_freeze_out, 1'h1)
      wake(1, note(1'h0, RST_VECTOR, VEC_PORTB), 32'h00003fff);
      {wdg_active_in, nmi_pin_in} <= 2'h0;
      apb(1'h1, OFS_OPTION, 32'h00000000, 32'h0, 1'h0);
      $display("test watchdog done");
      // Interrupts disabled: a pending port line is not enabled, NMI cannot wake, reset can
      apb(1'h1, OFS_IOPT, iopt_word(1'h0), 32'h0, 1'h0);
      src[0] <= 1'h1;
      apb(1'h1, OFS_CMD, 32'h00000001, 32'h0, 1'h0);
      wait_mode(2'h1);
      src[4] <= 1'h1;
      repeat (20) @(posedge clk_in);
      `CHK(mode_out, 2'h1)
      src[4:0] <= 5'h00;
      wake(5, note(1'h0, RST_VECTOR, VEC_RESET), 32'h00000fff);
      $display("test disabled done");
      // Enabled request pending: instruction ignored, port line for wait, NMI for halt
      apb(1'h1, OFS_IOPT, iopt_word(1'h1), 32'h0, 1'h0);
      for (int j = 0; j < 2; j++) begin
         src[j * 4] <= 1'h1;
         apb(1'h1, OFS_CMD, (j == 0) ? 32'h00000001 : 32'h00000002, 32'h0, 1'h0);
         repeat (10) @(posedge clk_in);
         `CHK(mode_out, 2'h0)
         src[j * 4] <= 1'h0;
         repeat (4) @(posedge clk_in);
      end
      $display("test pending done");
      // Restart context: NMI routine, interrupt routine woken by port, then by NMI
      for (int k = 0; k < 3; k++) begin
         ctx_req <= (k == 0) ? 2'h2 : 2'h1;
         repeat (3) @(posedge clk_in);
         apb(1'h1, OFS_CMD, 32'h00000001, 32'h0, 1'h0);
         wait_mode(2'h1);
         apb(1'h0, OFS_STATUS, (k == 0) ? 32'h00000020 : 32'h00000010, 32'h00000030, 1'h0);
         wake((k == 2) ? 4 : 0, (k == 2) ? note(1'h1, RST_NMI_FIRST, VEC_NMI) : note(1'h1, RST_NEXT, 12'h000),
              (k == 2) ? 32'h00007fff : 32'h00007000);
      end
      ctx_req <= 2'h0;
      $display("test context done");
      `CHK(apb_q.size() + load_q.size(), 0)
      summarize();
   end
endmodule
